// [prs_params.svh]
`ifndef PRS_PARAMS_SVH
`define PRS_PARAMS_SVH

// Register byte offsets
`define PRS_OFF_CTRL 12'h000
`define PRS_OFF_RDIV 12'h004
`define PRS_OFF_NDIV 12'h008
`define PRS_OFF_STAT 12'h00c

// Control register bit positions
`define PRS_CTRL_PLL_PD 0
`define PRS_CTRL_REF_EN 1
`define PRS_CTRL_DIFF_MODE 2
`define PRS_CTRL_PRI_PD 3
`define PRS_CTRL_SEC_PD 4
`define PRS_CTRL_AUTO 5
`define PRS_CTRL_STAY 6
`define PRS_CTRL_DEGLITCH 7
`define PRS_CTRL_MAN_SEC 8
`define PRS_CTRL_PIN_SEL 9
`define PRS_CTRL_CNT_RST 10
`define PRS_CTRL_SYNC_R 12
`define PRS_CTRL_SYNC_AB 13

// Feedback divider field positions
`define PRS_NDIV_MODE_LSB 0
`define PRS_NDIV_A_LSB 8
`define PRS_NDIV_B_LSB 16

// Status register bit positions
`define PRS_STAT_ON_SEC 0
`define PRS_STAT_MISSING 1
`define PRS_STAT_PENDING 2
`define PRS_STAT_DIFF_PD 3
`define PRS_STAT_PRI_PD 4
`define PRS_STAT_SEC_PD 5

// Writable masks and reset values
`define PRS_CTRL_MASK 32'h000037ff
`define PRS_RDIV_MASK 32'h00003fff
`define PRS_NDIV_MASK 32'h1fff3f07
`define PRS_CTRL_RESET 32'h00000000
`define PRS_RDIV_RESET 32'h00000001
`define PRS_NDIV_RESET 32'h00030000

// Edge counts of the reference monitor
`define PRS_MISS_FALLS 2'h2
`define PRS_RETURN_RISES 3'h4

`endif

// [prs_pkg.sv]
package prs_pkg;

	// Prescaler mode field encoding
	typedef enum logic [2:0] {
		PM_DM2 = 3'h0,
		PM_DM4 = 3'h1,
		PM_DM8 = 3'h2,
		PM_DM16 = 3'h3,
		PM_DM32 = 3'h4,
		PM_FD1 = 3'h5,
		PM_FD2 = 3'h6,
		PM_FD3 = 3'h7
	} prs_pmode_t;

	// Reference selection state
	typedef enum logic [1:0] {
		SEL_PRI = 2'h0,
		SEL_TO_SEC = 2'h1,
		SEL_SEC = 2'h2,
		SEL_TO_PRI = 2'h3
	} prs_sel_t;

	// Decoded prescaler setting
	typedef struct packed {
		logic dual;
		logic [5:0] base;
	} prs_pres_t;

	// Buffer power-down bundle
	typedef struct packed {
		logic diff;
		logic pri;
		logic sec;
	} prs_pd_t;

endpackage

// [prs_ref_select_div.sv]
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "prs_params.svh"

module prs_ref_select_div
	import prs_pkg::*;
#(
	parameter int R_W = 14,
	parameter int A_W = 6,
	parameter int B_W = 13
) (
	input wire logic pclk, // Bus and sampling clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic primary_ref, // Primary reference pin
	input wire logic secondary_ref, // Secondary reference pin
	input wire logic vco_fb, // VCO or external clock feedback
	input wire logic sync_n, // Sync pin, active low
	input wire logic ref_sel_pin, // Reference select pin
	output logic diff_buf_pd, // Differential buffer power-down
	output logic primary_buf_pd, // Primary buffer power-down
	output logic secondary_buf_pd, // Secondary buffer power-down
	output logic on_secondary, // Secondary selected, or return to primary pending
	output logic pfd_ref_pulse, // Reference divider output pulse
	output logic pfd_fb_pulse // Feedback divider output pulse
);

	// Field positions cap the widths
	if (R_W < 2 || R_W > 14 || A_W < 1 || A_W > 6 || B_W < 2 || B_W > 13) begin : g_chk
		$error("prs_ref_select_div: unsupported counter width");
	end

	localparam int NS = 5;
	localparam logic [NS-1:0] SYNC_INIT = 5'h08;

	logic [31:0] ctrl;
	logic [31:0] rdiv;
	logic [31:0] ndiv;
	logic [NS-1:0] raw_in;
	logic [NS-1:0] lvl;
	logic [NS-1:0] lvl_q;
	logic [NS-1:0] rise;
	logic [NS-1:0] fall;
	prs_sel_t sel_state;
	prs_pd_t next_pd;
	logic [1:0] fall_cnt;
	logic [1:0] sfall_cnt;
	logic [2:0] rise_cnt;
	logic missing;
	logic auto_sec;
	logic [R_W-1:0] r_cnt;
	logic [5:0] p_cnt;
	logic [B_W-1:0] b_cnt;
	logic [B_W-1:0] a_cnt;

	// Byte-lane merge for register writes
	function automatic logic [31:0] prs_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res & mask;
	endfunction

	// Prescaler mode decode
	function automatic prs_pres_t prs_decode(input logic [2:0] code);
		prs_pres_t d;
		d.dual = 1'b1;
		d.base = 6'h02;
		unique case (prs_pmode_t'(code))
			PM_DM2: d.base = 6'h02;
			PM_DM4: d.base = 6'h04;
			PM_DM8: d.base = 6'h08;
			PM_DM16: d.base = 6'h10;
			PM_DM32: d.base = 6'h20;
			PM_FD1: begin
				d.dual = 1'b0;
				d.base = 6'h01;
			end
			PM_FD2: begin
				d.dual = 1'b0;
				d.base = 6'h02;
			end
			PM_FD3: begin
				d.dual = 1'b0;
				d.base = 6'h03;
			end
		endcase
		return d;
	endfunction

	// Pin inputs: three flops, level moves when last two agree
	assign raw_in = {ref_sel_pin, sync_n, vco_fb, secondary_ref, primary_ref};
	for (genvar g = 0; g < NS; g++) begin : g_sync
		logic s1;
		logic s2;
		logic s3;
		logic held;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s1 <= SYNC_INIT[g];
				s2 <= SYNC_INIT[g];
				s3 <= SYNC_INIT[g];
				held <= SYNC_INIT[g];
			end else begin
				s1 <= raw_in[g];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					held <= s3;
				end
			end
		end
		assign lvl[g] = held;
	end

	// Edge detect on the filtered levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_q <= SYNC_INIT;
		end else begin
			lvl_q <= lvl;
		end
	end
	assign rise = lvl & ~lvl_q;
	assign fall = ~lvl & lvl_q;

	logic pri_rise, pri_edge, sec_rise, sec_fall, sync_low, pin_sec;
	assign pri_rise = rise[0];
	assign pri_edge = rise[0] | fall[0];
	assign sec_rise = rise[1];
	assign sec_fall = fall[1];
	assign sync_low = ~lvl[3];
	assign pin_sec = lvl[4];

	// Control fields
	logic pll_pd, ref_en, diff_mode, auto_mode, stay, deglitch;
	assign pll_pd = ctrl[`PRS_CTRL_PLL_PD];
	assign ref_en = ctrl[`PRS_CTRL_REF_EN];
	assign diff_mode = ctrl[`PRS_CTRL_DIFF_MODE];
	assign auto_mode = ctrl[`PRS_CTRL_AUTO];
	assign stay = ctrl[`PRS_CTRL_STAY];
	assign deglitch = ctrl[`PRS_CTRL_DEGLITCH];

	// APB decode; reads take a word snapshot at the setup edge
	logic setup, wr_ok, unmapped;
	logic [31:0] stat_word;
	logic [31:0] rd_word;
	assign setup = psel & ~penable;
	assign wr_ok = psel & penable & pready & pwrite & ~pslverr;
	always_comb begin
		stat_word = 32'h00000000;
		stat_word[`PRS_STAT_ON_SEC] = on_secondary;
		stat_word[`PRS_STAT_MISSING] = missing;
		stat_word[`PRS_STAT_PENDING] = (sel_state == SEL_TO_SEC) || (sel_state == SEL_TO_PRI);
		stat_word[`PRS_STAT_DIFF_PD] = diff_buf_pd;
		stat_word[`PRS_STAT_PRI_PD] = primary_buf_pd;
		stat_word[`PRS_STAT_SEC_PD] = secondary_buf_pd;
		unmapped = 1'b0;
		case (paddr)
			`PRS_OFF_CTRL: rd_word = ctrl;
			`PRS_OFF_RDIV: rd_word = rdiv;
			`PRS_OFF_NDIV: rd_word = ndiv;
			`PRS_OFF_STAT: rd_word = stat_word;
			default: begin
				rd_word = 32'h00000000;
				unmapped = 1'b1;
			end
		endcase
	end

	// No wait state: answer registered during setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h00000000 : rd_word;
			pslverr <= unmapped | (pwrite && paddr == `PRS_OFF_STAT);
		end else begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	// Register writes; reset leaves every reference disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `PRS_CTRL_RESET;
			rdiv <= `PRS_RDIV_RESET;
			ndiv <= `PRS_NDIV_RESET;
		end else if (wr_ok) begin
			if (paddr == `PRS_OFF_CTRL) begin
				ctrl <= prs_merge(ctrl, pwdata, pstrb, `PRS_CTRL_MASK);
			end
			if (paddr == `PRS_OFF_RDIV) begin
				rdiv <= prs_merge(rdiv, pwdata, pstrb, `PRS_RDIV_MASK);
			end
			if (paddr == `PRS_OFF_NDIV) begin
				ndiv <= prs_merge(ndiv, pwdata, pstrb, `PRS_NDIV_MASK);
			end
		end
	end

	// Buffer power-down decode
	always_comb begin
		next_pd.diff = pll_pd | ~ref_en | ~diff_mode;
		next_pd.pri = pll_pd | ~ref_en | diff_mode | ctrl[`PRS_CTRL_PRI_PD];
		next_pd.sec = pll_pd | ~ref_en | diff_mode | ctrl[`PRS_CTRL_SEC_PD];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			diff_buf_pd <= 1'b1;
			primary_buf_pd <= 1'b1;
			secondary_buf_pd <= 1'b1;
		end else begin
			diff_buf_pd <= next_pd.diff;
			primary_buf_pd <= next_pd.pri;
			secondary_buf_pd <= next_pd.sec;
		end
	end

	// Primary monitor, watched by secondary falls
	logic miss_set, recover;
	assign miss_set = ~missing & sec_fall & ~pri_edge & (fall_cnt == `PRS_MISS_FALLS - 2'h1);
	assign recover = missing & pri_rise & (sfall_cnt != 2'h2) &
		(rise_cnt == `PRS_RETURN_RISES - 3'h1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fall_cnt <= 2'h0;
			sfall_cnt <= 2'h0;
			rise_cnt <= 3'h0;
			missing <= 1'b0;
		end else begin
			if (pri_edge) begin
				fall_cnt <= 2'h0;
			end else if (sec_fall && fall_cnt != `PRS_MISS_FALLS) begin
				fall_cnt <= fall_cnt + 2'h1;
			end
			if (pri_rise) begin
				sfall_cnt <= 2'h0;
			end else if (sec_fall && sfall_cnt != 2'h2) begin
				sfall_cnt <= sfall_cnt + 2'h1;
			end
			// Two secondary falls restart the return count
			if (miss_set) begin
				rise_cnt <= 3'h0;
			end else if (pri_rise) begin
				rise_cnt <= (sfall_cnt == 2'h2) ? 3'h1 : rise_cnt + 3'h1;
			end
			if (miss_set) begin
				missing <= 1'b1;
			end else if (recover) begin
				missing <= 1'b0;
			end
		end
	end

	// Automatic choice; leaving auto mode drops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			auto_sec <= 1'b0;
		end else if (!auto_mode || diff_mode) begin
			auto_sec <= 1'b0;
		end else if (miss_set) begin
			auto_sec <= 1'b1;
		end else if (recover && !stay) begin
			// prefer mode returns, stay mode holds
			auto_sec <= 1'b0;
		end
	end

	// Requested reference and switching state
	logic want_sec, hold_gate;
	assign want_sec = auto_mode ? auto_sec :
		(ctrl[`PRS_CTRL_PIN_SEL] ? pin_sec : ctrl[`PRS_CTRL_MAN_SEC]);
	// Auto entry to secondary always waits for its rising edge
	assign hold_gate = deglitch | auto_mode;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_state <= SEL_PRI;
		end else begin
			unique case (sel_state)
				SEL_PRI: if (want_sec && !diff_mode) begin
					sel_state <= hold_gate ? SEL_TO_SEC : SEL_SEC;
				end
				SEL_TO_SEC: if (!want_sec || diff_mode) begin
					sel_state <= SEL_PRI;
				end else if (sec_rise) begin
					sel_state <= SEL_SEC;
				end
				SEL_SEC: if (!want_sec || diff_mode) begin
					sel_state <= deglitch ? SEL_TO_PRI : SEL_PRI;
				end
				SEL_TO_PRI: if (want_sec && !diff_mode) begin
					sel_state <= SEL_SEC;
				end else if (pri_rise) begin
					sel_state <= SEL_PRI;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_secondary <= 1'b0;
		end else begin
			on_secondary <= (sel_state == SEL_SEC) || (sel_state == SEL_TO_PRI);
		end
	end

	// Reference edge into the divider; old reference blocked while pending
	logic ref_edge;
	always_comb begin
		if (diff_mode) begin
			ref_edge = pri_rise & ~diff_buf_pd;
		end else if (sel_state == SEL_PRI || sel_state == SEL_TO_PRI) begin
			ref_edge = pri_rise & ~primary_buf_pd;
		end else begin
			ref_edge = sec_rise & ~secondary_buf_pd;
		end
	end

	// Counter resets from software bit or sync pin
	logic r_rst, ab_rst;
	assign r_rst = ctrl[`PRS_CTRL_CNT_RST] | (ctrl[`PRS_CTRL_SYNC_R] & sync_low);
	assign ab_rst = ctrl[`PRS_CTRL_CNT_RST] | (ctrl[`PRS_CTRL_SYNC_AB] & sync_low);

	// Reference divider
	logic [R_W-1:0] r_val, r_last;
	assign r_val = rdiv[R_W-1:0];
	// zero and one divide by one
	assign r_last = (r_val < R_W'(2)) ? '0 : r_val - R_W'(1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_cnt <= '0;
			pfd_ref_pulse <= 1'b0;
		end else if (r_rst) begin
			r_cnt <= '0;
			pfd_ref_pulse <= 1'b0;
		end else if (ref_edge) begin
			if (r_cnt >= r_last) begin
				r_cnt <= '0;
				pfd_ref_pulse <= 1'b1;
			end else begin
				r_cnt <= r_cnt + R_W'(1);
				pfd_ref_pulse <= 1'b0;
			end
		end else begin
			pfd_ref_pulse <= 1'b0;
		end
	end

	// Feedback divider settings
	prs_pres_t pres;
	logic [B_W-1:0] a_eff, b_last;
	logic [5:0] cur_mod;
	logic pres_tick;
	assign pres = prs_decode(ndiv[`PRS_NDIV_MODE_LSB +: 3]);
	// swallow unused in fixed mode; zero is zero
	assign a_eff = pres.dual ? B_W'(ndiv[`PRS_NDIV_A_LSB +: A_W]) : '0;
	assign b_last = (ndiv[`PRS_NDIV_B_LSB +: B_W] == '0) ? '0 :
		ndiv[`PRS_NDIV_B_LSB +: B_W] - B_W'(1);
	assign cur_mod = pres.base + {5'h00, (pres.dual && a_cnt < a_eff)};
	assign pres_tick = rise[2] && (p_cnt >= cur_mod - 6'h01);

	// Prescaler counts feedback clock edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_cnt <= 6'h00;
		end else if (ab_rst) begin
			p_cnt <= 6'h00;
		end else if (rise[2]) begin
			p_cnt <= pres_tick ? 6'h00 : p_cnt + 6'h01;
		end
	end

	// main and swallow counters on prescaler output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			b_cnt <= '0;
			a_cnt <= '0;
			pfd_fb_pulse <= 1'b0;
		end else if (ab_rst) begin
			b_cnt <= '0;
			a_cnt <= '0;
			pfd_fb_pulse <= 1'b0;
		end else if (pres_tick) begin
			if (b_cnt >= b_last) begin
				b_cnt <= '0;
				a_cnt <= '0;
				pfd_fb_pulse <= 1'b1;
			end else begin
				b_cnt <= b_cnt + B_W'(1);
				a_cnt <= a_cnt + B_W'(1);
				pfd_fb_pulse <= 1'b0;
			end
		end else begin
			pfd_fb_pulse <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [prs_ref_select_div_chk.sv]
`timescale 1ns/1ns
`default_nettype none
`include "prs_params.svh"

module prs_ref_select_div_chk (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Access phase
	input wire logic pwrite, // Direction
	input wire logic [11:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic secondary_ref, // Secondary pin
	input wire logic diff_buf_pd, // Diff power-down
	input wire logic primary_buf_pd, // Primary power-down
	input wire logic secondary_buf_pd, // Secondary power-down
	input wire logic on_secondary, // Secondary selected
	input wire logic pfd_ref_pulse, // Reference pulse
	input wire logic pfd_fb_pulse // Feedback pulse
);
	logic [13:0] sh;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Control shadow; no wait states, so the access edge is psel with penable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh <= 14'h0000;
		end else if (psel && penable && pwrite && paddr == `PRS_OFF_CTRL) begin
			sh <= pwdata[13:0] & 14'h37ff;
		end
	end

	property p_all_off;
		!$past(sh[1]) |-> diff_buf_pd && primary_buf_pd && secondary_buf_pd;
	endproperty
	a_all_off: assert property (p_all_off) else $error("buffer on while off");
	property p_diff_pd;
		diff_buf_pd == ($past(sh[0]) || !$past(sh[1]) || !$past(sh[2]));
	endproperty
	a_diff_pd: assert property (p_diff_pd) else $error("diff power-down wrong");
	property p_pri_pd;
		primary_buf_pd == ($past(sh[0]) || !$past(sh[1]) || $past(sh[2]) || $past(sh[3]));
	endproperty
	a_pri_pd: assert property (p_pri_pd) else $error("primary power-down wrong");
	property p_sec_pd;
		secondary_buf_pd == ($past(sh[0]) || !$past(sh[1]) || $past(sh[2]) || $past(sh[4]));
	endproperty
	a_sec_pd: assert property (p_sec_pd) else $error("secondary power-down wrong");
	property p_se_off;
		!diff_buf_pd |-> primary_buf_pd && secondary_buf_pd;
	endproperty
	a_se_off: assert property (p_se_off) else $error("single-ended on in diff");
	property p_cnt_hold;
		sh[10] && $past(sh[10], 3) |-> !pfd_ref_pulse && !pfd_fb_pulse;
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("pulse during reset");
	property p_sw_rise;
		$rose(on_secondary) && (sh[5] || sh[7]) |-> secondary_ref;
	endproperty
	a_sw_rise: assert property (p_sw_rise) else $error("switch off a rise");
	property p_one_pulse;
		pfd_ref_pulse |=> !pfd_ref_pulse;
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("pulse too long");

	c_switch: cover property ($rose(on_secondary));
	c_ref: cover property (pfd_ref_pulse);
	c_fb: cover property (pfd_fb_pulse);
endmodule

bind prs_ref_select_div prs_ref_select_div_chk u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .secondary_ref, .diff_buf_pd,
	.primary_buf_pd, .secondary_buf_pd, .on_secondary, .pfd_ref_pulse, .pfd_fb_pulse
);

`default_nettype wire

// [prs_ref_src.sv]
`timescale 1ns/1ns
`default_nettype none

module prs_ref_src #(
	parameter int P_HALF = 4,
	parameter int S_HALF = 8,
	parameter int V_HALF = 3
) (
	input wire logic pclk, // Sampling clock
	input wire logic [2:0] run, // Enables: vco, secondary, primary
	output logic primary_ref, // Primary reference
	output logic secondary_ref, // Secondary reference
	output logic vco_fb // Feedback clock
);
	int cnt [3] = '{0, 0, 0};
	logic [2:0] lvl = 3'h0;

	function automatic int half(input int i);
		return (i == 0) ? P_HALF : ((i == 1) ? S_HALF : V_HALF);
	endfunction

	// Stopped clock ends its high half then rests low, always driven
	always_ff @(posedge pclk) begin
		for (int i = 0; i < 3; i++) begin
			if (!run[i] && !lvl[i]) begin
				cnt[i] <= 0;
			end else if (cnt[i] == half(i) - 1) begin
				cnt[i] <= 0;
				lvl[i] <= ~lvl[i];
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end

	assign primary_ref = lvl[0];
	assign secondary_ref = lvl[1];
	assign vco_fb = lvl[2];
endmodule

`default_nettype wire

// [tb_prs_ref_select_div.sv]
`timescale 1ns/1ns
`default_nettype none
`include "prs_params.svh"

module tb_prs_ref_select_div
	import prs_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic sync_n = 1'b1;
	logic ref_sel_pin = 1'b0;
	logic [2:0] run = 3'h0;
	logic pp = 1'b0;
	logic pv = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, primary_ref, secondary_ref, vco_fb;
	logic diff_buf_pd, primary_buf_pd, secondary_buf_pd, on_secondary, pfd_ref_pulse, pfd_fb_pulse;
	int miscompares = 0;
	int tests_run = 0;
	int n_pri = 0, n_vco = 0, n_rp = 0, n_fp = 0;
	int d_pri, d_vco, d_rp, d_fp;

	always #25 pclk = ~pclk;

	prs_ref_select_div u_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .primary_ref, .secondary_ref, .vco_fb, .sync_n, .ref_sel_pin, .diff_buf_pd,
		.primary_buf_pd, .secondary_buf_pd, .on_secondary, .pfd_ref_pulse, .pfd_fb_pulse
	);
	prs_ref_src u_src (.pclk, .run, .primary_ref, .secondary_ref, .vco_fb);

	// Pin rises and detector pulses, seen as sampled at each edge
	always @(posedge pclk) begin
		n_pri += (primary_ref && !pp);
		n_vco += (vco_fb && !pv);
		n_rp += (pfd_ref_pulse === 1'b1);
		n_fp += (pfd_fb_pulse === 1'b1);
		pp = primary_ref;
		pv = vco_fb;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk1(n < 16, 1'b1);
	endtask

	// Run sources, then let the last edges drain through the pin filters
	task automatic run_src(input logic [2:0] m, input int cyc);
		int s0, s1, s2, s3;
		s0 = n_pri;
		s1 = n_vco;
		s2 = n_rp;
		s3 = n_fp;
		run <= m;
		repeat (cyc) @(posedge pclk);
		run <= 3'h0;
		repeat (30) @(posedge pclk);
		d_pri = n_pri - s0;
		d_vco = n_vco - s1;
		d_rp = n_rp - s2;
		d_fp = n_fp - s3;
	endtask

	task automatic wait_on(input logic v, input logic [2:0] m);
		int n;
		run <= m;
		n = 0;
		while (on_secondary !== v && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk1(on_secondary, v);
	endtask

	task automatic t_regs;
		logic [11:0] a [3] = '{`PRS_OFF_CTRL, `PRS_OFF_RDIV, `PRS_OFF_NDIV};
		logic [31:0] e [3] = '{`PRS_CTRL_RESET, `PRS_RDIV_RESET, `PRS_NDIV_RESET};
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, a[i], 32'h0);
			chk(rd, e[i]);
		end
		apb(1'b0, 12'h010, 32'h0);
		chk1(er, 1'b1);
		apb(1'b1, `PRS_OFF_RDIV, 32'hffffffff);
		apb(1'b0, `PRS_OFF_RDIV, 32'h0);
		chk(rd, 32'h00003fff);
		pstrb <= 4'h2;
		apb(1'b1, `PRS_OFF_RDIV, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, `PRS_OFF_RDIV, 32'h0);
		chk(rd, 32'h000000ff);
		apb(1'b1, `PRS_OFF_STAT, 32'h0);
		chk1(er, 1'b1);
		$display("regs done");
	endtask

	task automatic t_bufs;
		logic [31:0] c [7] = '{32'h0, 32'h2, 32'h3, 32'h6, 32'h4, 32'ha, 32'h12};
		logic [2:0] x;
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, `PRS_OFF_CTRL, c[i]);
			repeat (2) @(posedge pclk);
			x[2] = c[i][0] | !c[i][1] | !c[i][2];
			x[1] = c[i][0] | !c[i][1] | c[i][2] | c[i][3];
			x[0] = c[i][0] | !c[i][1] | c[i][2] | c[i][4];
			chk({diff_buf_pd, primary_buf_pd, secondary_buf_pd}, x);
			apb(1'b0, `PRS_OFF_STAT, 32'h0);
			chk({rd[3], rd[4], rd[5]}, x);
		end
		$display("bufs done");
	endtask

	task automatic t_rdiv;
		int r [4] = '{0, 1, 3, 7};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `PRS_OFF_CTRL, 32'h402);
			apb(1'b1, `PRS_OFF_RDIV, r[i]);
			run_src(3'h5, 300);
			chk(d_rp + d_fp, 32'h0);
			apb(1'b1, `PRS_OFF_CTRL, 32'h2);
			run_src(3'h1, 400);
			chk(d_rp, d_pri / (r[i] > 1 ? r[i] : 1));
		end
		$display("rdiv done");
	endtask

	task automatic t_ndiv;
		prs_pmode_t m [8] = '{PM_DM2, PM_DM4, PM_DM8, PM_DM16, PM_DM32, PM_FD1, PM_FD2, PM_FD3};
		int a [8] = '{1, 0, 2, 1, 0, 0, 2, 0};
		int b [8] = '{3, 3, 3, 3, 3, 1, 3, 4};
		int n [8] = '{7, 12, 26, 49, 96, 1, 6, 12};
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, `PRS_OFF_CTRL, 32'h402);
			apb(1'b1, `PRS_OFF_NDIV, (b[i] << 16) | (a[i] << 8) | m[i]);
			apb(1'b1, `PRS_OFF_CTRL, 32'h2);
			run_src(3'h4, 1200);
			chk(d_fp, d_vco / n[i]);
		end
		$display("ndiv done");
	endtask

	task automatic t_sync;
		apb(1'b1, `PRS_OFF_RDIV, 32'h1);
		sync_n <= 1'b0;
		run_src(3'h5, 400);
		chk(d_rp, d_pri);
		apb(1'b1, `PRS_OFF_CTRL, 32'h3002);
		run_src(3'h5, 400);
		chk(d_rp + d_fp, 32'h0);
		sync_n <= 1'b1;
		$display("sync done");
	endtask

	task automatic t_switch;
		apb(1'b1, `PRS_OFF_CTRL, 32'ha2);
		run_src(3'h3, 100);
		chk1(on_secondary, 1'b0);
		wait_on(1'b1, 3'h2);
		apb(1'b0, `PRS_OFF_STAT, 32'h0);
		chk1(rd[1], 1'b1);
		wait_on(1'b0, 3'h3);
		apb(1'b1, `PRS_OFF_CTRL, 32'he2);
		wait_on(1'b1, 3'h2);
		// Primary comes back; stay mode must not follow it
		run <= 3'h3;
		repeat (200) @(posedge pclk);
		chk1(on_secondary, 1'b1);
		apb(1'b1, `PRS_OFF_CTRL, 32'h82);
		wait_on(1'b0, 3'h3);
		run <= 3'h1;
		repeat (30) @(posedge pclk);
		apb(1'b1, `PRS_OFF_CTRL, 32'h182);
		repeat (150) @(posedge pclk);
		chk1(on_secondary, 1'b0);
		wait_on(1'b1, 3'h3);
		apb(1'b1, `PRS_OFF_CTRL, 32'h202);
		wait_on(1'b0, 3'h3);
		ref_sel_pin <= 1'b1;
		wait_on(1'b1, 3'h3);
		apb(1'b1, `PRS_OFF_CTRL, 32'h206);
		wait_on(1'b0, 3'h0);
		chk({diff_buf_pd, primary_buf_pd, secondary_buf_pd}, 32'h3);
		ref_sel_pin <= 1'b0;
		$display("switch done");
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Main sequence after five reset cycles
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_bufs();
		t_rdiv();
		t_ndiv();
		t_sync();
		t_switch();
		tally_and_finish();
	end

	// Watchdog, well past the expected run length
	initial begin
		#(50 * 60000);
		miscompares++;
		tally_and_finish();
	end
endmodule

`default_nettype wire
